// ### dv/ppfm_board.sv
`timescale 1ns/1ps
// Board side of the pads: a pin left undriven by the device takes the
// level that other board logic puts on it, never the device's last value
module ppfm_board #(
   parameter realtime REF_HALF = 40.0
) (
   input  wire ppfm_pkg::ppfm_pins_t pa_pins,
   input  wire ppfm_pkg::ppfm_pins_t pc_pins,
   input  wire logic [7:0]           ext_pa,
   input  wire logic [7:0]           ext_pc,
   output logic      [7:0]           pa_in,
   output logic      [7:0]           pc_in,
   output logic                      ref_clk
);
   import ppfm_pkg::*;

   // Pad level per bit: device drive wins where its enable is low
   assign pa_in = (pa_pins.out & ~pa_pins.oe_n) | (ext_pa & pa_pins.oe_n);
   assign pc_in = (pc_pins.out & ~pc_pins.oe_n) | (ext_pc & pc_pins.oe_n);

   // Free-running reference oscillator, phase unrelated to the core clock
   initial begin
      ref_clk = 1'b0;
      #7.3;
      forever #(REF_HALF) ref_clk = ~ref_clk;
   end
endmodule : ppfm_board

// ### dv/ppfm_tb_top.sv
`timescale 1ns/1ps
// Pad multiplexer driven through its register bus
module ppfm_tb_top;
   import ppfm_pkg::*;
   logic        mclk, resetn, awvalid, awready, wvalid, wready, bvalid;
   logic        arvalid, arready, rvalid, ref_clk, strap, wakeup_n;
   logic        ck_pin, ck_oe_n, osc_run, wake_irq;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb;
   logic [7:0]  pa_in, pc_in, ext_pa, ext_pc;
   ppfm_alt_t   alt;
   ppfm_pins_t  pa_pins, pc_pins;
   int          n_errors, checked, edges;

   // Core clock, 100 MHz
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Rising edges seen on the clock output pin
   always @(posedge ck_pin) edges = edges + 1;

   ppfm_top uut (
      .mclk(mclk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .alt(alt),
      .pa_in(pa_in), .pa_pins(pa_pins), .pc_in(pc_in), .pc_pins(pc_pins),
      .ref_clk_in(ref_clk), .half_speed_strap(strap), .wakeup_n(wakeup_n),
      .clock_out_pin(ck_pin), .clock_out_oe_n(ck_oe_n), .osc_run(osc_run),
      .wake_irq(wake_irq)
   );

   ppfm_board board (
      .pa_pins(pa_pins), .pc_pins(pc_pins), .ext_pa(ext_pa), .ext_pc(ext_pc),
      .pa_in(pa_in), .pc_in(pc_in), .ref_clk(ref_clk)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Write: both halves offered together, each released once taken
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge mclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'h000000, d};
      wvalid  <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr

   // Read: no cycle count assumed, wait for the answer
   task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rd

   // Only driven bits are compared; an undriven level is left open
   task automatic pin_chk(input logic c, input logic [7:0] o, input logic [7:0] e);
      ppfm_pins_t p;
      #1;
      p = c ? pc_pins : pa_pins;
      chk({16'h0000, p.out & ~p.oe_n, p.oe_n}, {16'h0000, o & ~e, e});
   endtask : pin_chk

   // Count clock-out edges over ten reference periods after settling
   task automatic ck_count(input int lo, input int hi);
      repeat (40) @(posedge mclk);
      edges = 0;
      repeat (80) @(posedge mclk);
      chk(32'(edges >= lo && edges <= hi), 32'h1);
   endtask : ck_count

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      resetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
      awaddr = 6'h00; araddr = 6'h00; wdata = 32'h0; alt = '1; wstrb = 4'hF;
      ext_pa = 8'h3C; ext_pc = 8'h5A; strap = 1'b0; wakeup_n = 1'b1;
      n_errors = 0; checked = 0; edges = 0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      pin_chk(1'b0, 8'h00, 8'hFF);
      pin_chk(1'b1, 8'h00, 8'hFF);
      rd(OFF_PA_FUNC, 32'h0, RESP_OKAY);
      rd(OFF_PA_PIN, 32'h3C, RESP_OKAY);
      rd(OFF_CPU_CS, 32'h2, RESP_OKAY);
      // All port A functions on, inputs elsewhere
      wr(OFF_PA_OUT, 8'hA5, RESP_OKAY);
      alt <= 11'h184;
      wr(OFF_PA_FUNC, 8'hFF, RESP_OKAY);
      pin_chk(1'b0, 8'h95, 8'h07);
      rd(OFF_PA_FUNC, 32'hF8, RESP_OKAY);
      // Echo pins hold 1 in every asynchronous mode
      for (int m = 1; m < 4; m++) begin
         @(posedge mclk);
         alt.s0_mode <= 2'(m);
         alt.s1_mode <= 2'(m);
         alt.s1_data <= 1'b0;
         pin_chk(1'b0, 8'hD5, 8'h07);
      end
      @(posedge mclk);
      alt.s0_mode <= SER_SYNC;
      alt.s1_mode <= SER_SYNC;
      pin_chk(1'b0, 8'h15, 8'h07);
      // Pins go back to the port with the output latch untouched
      wr(OFF_PA_FUNC, 8'h00, RESP_OKAY);
      wr(OFF_PA_DIR, 8'hFF, RESP_OKAY);
      pin_chk(1'b0, 8'hA5, 8'h00);
      // A write without byte lane 0 must leave the latch alone
      wstrb <= 4'hE;
      wr(OFF_PA_OUT, 8'h00, RESP_OKAY);
      wstrb <= 4'hF;
      pin_chk(1'b0, 8'hA5, 8'h00);
      wr(OFF_PA_FUNC, 8'h10, RESP_OKAY);
      pin_chk(1'b0, 8'hB5, 8'h00);
      wr(OFF_PA_FUNC, 8'h00, RESP_OKAY);
      pin_chk(1'b0, 8'hA5, 8'h00);
      // Port C memory strobes
      wr(OFF_PC_FUNC, 8'hFF, RESP_OKAY);
      pin_chk(1'b1, 8'h80, 8'h3F);
      rd(OFF_PC_FUNC, 32'hC0, RESP_OKAY);
      @(posedge mclk);
      alt.mem_wr_n <= 1'b1;
      alt.mem_rd_n <= 1'b0;
      pin_chk(1'b1, 8'h40, 8'h3F);
      wr(OFF_PC_FUNC, 8'h00, RESP_OKAY);
      pin_chk(1'b1, 8'h00, 8'hFF);
      rd(OFF_PC_PIN, 32'h5A, RESP_OKAY);
      // Unmapped places are refused
      rd(6'h24, 32'h0, RESP_SLVERR);
      wr(6'h3C, 8'hFF, RESP_SLVERR);
      // Clock out at double and at reference rate, then gated
      ck_count(19, 21);
      strap <= 1'b1;
      ck_count(9, 11);
      rd(OFF_CPU_CS, 32'hA, RESP_OKAY);
      wr(OFF_CPU_CS, 8'h00, RESP_OKAY);
      ck_count(0, 0);
      chk({31'h0, ck_oe_n}, 32'h1);
      wr(OFF_CPU_CS, 8'h02, RESP_OKAY);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, ck_oe_n}, 32'h0);
      // Suspend refused while wake-up is held low
      @(posedge mclk);
      wakeup_n <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(OFF_CPU_CS, 8'h03, RESP_OKAY);
      repeat (3) @(posedge mclk);
      #1 chk({31'h0, osc_run}, 32'h1);
      @(posedge mclk);
      wakeup_n <= 1'b1;
      repeat (4) @(posedge mclk);
      wr(OFF_CPU_CS, 8'h03, RESP_OKAY);
      repeat (3) @(posedge mclk);
      #1 chk({31'h0, osc_run}, 32'h0);
      // Falling wake-up edge restarts the oscillator and flags it
      @(posedge mclk);
      wakeup_n <= 1'b0;
      repeat (8) @(posedge mclk);
      #1 chk({30'h0, osc_run, wake_irq}, 32'h3);
      rd(OFF_CPU_CS, 32'hE, RESP_OKAY);
      wr(OFF_CPU_CS, 8'h06, RESP_OKAY);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, wake_irq}, 32'h0);
      report_and_stop();
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      report_and_stop();
   end
endmodule : ppfm_tb_top

// ### logic/ppfm_pkg.sv
package ppfm_pkg;

   // Register byte offsets on the AXI4-Lite slave
   localparam int          ADDR_W       = 6;
   localparam logic [5:0]  OFF_PA_FUNC  = 6'h00;
   localparam logic [5:0]  OFF_PC_FUNC  = 6'h04;
   localparam logic [5:0]  OFF_PA_OUT   = 6'h08;
   localparam logic [5:0]  OFF_PA_DIR   = 6'h0C;
   localparam logic [5:0]  OFF_PC_OUT   = 6'h10;
   localparam logic [5:0]  OFF_PC_DIR   = 6'h14;
   localparam logic [5:0]  OFF_PA_PIN   = 6'h18;
   localparam logic [5:0]  OFF_PC_PIN   = 6'h1C;
   localparam logic [5:0]  OFF_CPU_CS   = 6'h20;

   // Field positions in port_a_function_reg
   localparam int          PA_CS_BIT    = 3;
   localparam int          PA_FST_BIT   = 4;
   localparam int          PA_FLD_BIT   = 5;
   localparam int          PA_RX0_BIT   = 6;
   localparam int          PA_RX1_BIT   = 7;
   // Field positions in port_c_function_reg
   localparam int          PC_WR_BIT    = 6;
   localparam int          PC_RD_BIT    = 7;
   // Writable masks of the two function registers
   localparam logic [7:0]  PA_FUNC_MASK = 8'hF8;
   localparam logic [7:0]  PC_FUNC_MASK = 8'hC0;

   // Field positions in cpu_control_status_reg
   localparam int          CS_SUSP_BIT  = 0;
   localparam int          CS_GATE_BIT  = 1;
   localparam int          CS_WAKE_BIT  = 2;
   localparam int          CS_HALF_BIT  = 3;

   // Values after reset, and the synchronous serial mode code
   localparam logic [7:0]  RST_FUNC     = 8'h00;
   localparam logic [7:0]  RST_PORT     = 8'h00;
   localparam logic        RST_GATE     = 1'h1;
   localparam logic [1:0]  SER_SYNC     = 2'h0;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // Power state of the core oscillator
   typedef enum logic [0:0] {
      PPFM_RUN  = 1'b0,
      PPFM_SUSP = 1'b1
   } ppfm_pwr_t;

   // Alternate-function sources from the core, same clock
   typedef struct packed {
      logic       mem_cs_n;
      logic       mem_wr_n;
      logic       mem_rd_n;
      logic       fifo_wr_n;
      logic       fifo_rd_n;
      logic       s0_data;
      logic [1:0] s0_mode;
      logic       s1_data;
      logic [1:0] s1_mode;
   } ppfm_alt_t;

   // One 8-bit port towards its pads
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } ppfm_pins_t;

endpackage : ppfm_pkg

// ### logic/ppfm_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage is visible outside
module ppfm_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_chk
      $error("ppfm_sync: WIDTH must be at least 1");
   end

   // First stage feeds the second and nothing else
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : ppfm_sync

// ### logic/ppfm_top.sv
// Behaviour
// R1: Select 0 leaves port A bit 3 input I/O; 1 drives memory chip select.
// R2: FIFO store select 1 drives FIFO write strobe on bit 4, else port I/O.
// R3: FIFO load select 1 drives FIFO read strobe on bit 5, else port I/O.
// R4: Serial 0 echo select resets 0 leaving bit 6 I/O; 1 drives echo.
// R5: Serial 0 echo carries data only in synchronous mode 0, otherwise 1.
// R6: Serial 1 echo select resets 0 leaving bit 7 I/O; 1 drives echo.
// R7: Serial 1 echo carries data only in mode 0; modes 1 to 3 give 1.
// R8: Port C bit 6 select 1 drives memory write strobe, else port I/O.
// R9: Port C bit 7 select 1 drives memory read strobe, else port I/O.
// R10: Clock out runs at twice the reference, or at reference in reduced speed.
// R11: Clock out pin is not driven while the gate bit is 0.
// R12: Wake-up falling edge in suspend restarts oscillator and raises an interrupt.
// R13: Suspend is never entered while wake-up input is held low.
// R14: Select changes reach the pin next cycle; port output latch unchanged.
`timescale 1ns/1ps
module ppfm_top #(
   parameter int CNT_W = 8
) (
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   input  wire logic [ppfm_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic      [1:0]                 s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [ppfm_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic      [31:0]                s_axi_rdata,
   output logic      [1:0]                 s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire ppfm_pkg::ppfm_alt_t        alt,
   input  wire logic [7:0]                 pa_in,
   output ppfm_pkg::ppfm_pins_t            pa_pins,
   input  wire logic [7:0]                 pc_in,
   output ppfm_pkg::ppfm_pins_t            pc_pins,
   input  wire logic                       ref_clk_in,
   input  wire logic                       half_speed_strap,
   input  wire logic                       wakeup_n,
   output logic                            clock_out_pin,
   output logic                            clock_out_oe_n,
   output logic                            osc_run,
   output logic                            wake_irq
);
   import ppfm_pkg::*;

   if (CNT_W < 3) begin : g_chk
      $error("ppfm_top: CNT_W must be at least 3");
   end

   // Echo output: data only in synchronous mode, idle high otherwise
   function automatic logic ppfm_echo(input logic data, input logic [1:0] mode);
      return (mode == SER_SYNC) ? data : 1'h1;
   endfunction : ppfm_echo

   // Address decode shared by the read and the write path
   function automatic logic ppfm_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFF_PA_FUNC) || (a == OFF_PC_FUNC) || (a == OFF_PA_OUT) ||
             (a == OFF_PA_DIR)  || (a == OFF_PC_OUT)  || (a == OFF_PC_DIR) ||
             (a == OFF_PA_PIN)  || (a == OFF_PC_PIN)  || (a == OFF_CPU_CS);
   endfunction : ppfm_mapped

   logic [7:0]        port_a_function_reg_q;
   logic [7:0]        port_c_function_reg_q;
   logic [7:0]        pa_out_q;
   logic [7:0]        pa_dir_q;
   logic [7:0]        pc_out_q;
   logic [7:0]        pc_dir_q;
   logic              clock_out_gate_q;
   logic              wake_flag_q;
   ppfm_pwr_t         pwr_q;
   ppfm_pwr_t         pwr_d;
   logic              wake_d_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [7:0]        wbyte_q;
   logic              wstrb0_q;
   logic              aw_have_q;
   logic              w_have_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [31:0]       rdata_q;
   logic [7:0]        pa_sync;
   logic [7:0]        pc_sync;
   logic              ref_sync;
   logic              half_sync;
   logic              wake_sync;
   logic              ref_d_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  half_per_q;
   logic              dbl_q;
   logic              clk_out_q;
   logic              clk_oe_n_q;

   // Every pad input and the strap pass two flops first
   ppfm_sync #(
      .WIDTH   (19),
      .RST_VAL (19'h00001)
   ) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .d      ({pa_in, pc_in, ref_clk_in, half_speed_strap, wakeup_n}),
      .q      ({pa_sync, pc_sync, ref_sync, half_sync, wake_sync})
   );

   // AXI handshakes; one write and one read in flight at most
   wire do_wr = aw_have_q && w_have_q;
   wire rd_go = s_axi_arvalid && !rvalid_q;
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   // Byte lane 0 carries every register; other lanes are ignored
   wire wr_ok    = do_wr && wstrb0_q;
   wire wr_pa_fn = wr_ok && (waddr_q == OFF_PA_FUNC);
   wire wr_pc_fn = wr_ok && (waddr_q == OFF_PC_FUNC);
   wire wr_pa_o  = wr_ok && (waddr_q == OFF_PA_OUT);
   wire wr_pa_d  = wr_ok && (waddr_q == OFF_PA_DIR);
   wire wr_pc_o  = wr_ok && (waddr_q == OFF_PC_OUT);
   wire wr_pc_d  = wr_ok && (waddr_q == OFF_PC_DIR);
   wire wr_cs    = wr_ok && (waddr_q == OFF_CPU_CS);
   wire susp_req = wr_cs && wbyte_q[CS_SUSP_BIT];
   wire wake_clr = wr_cs && wbyte_q[CS_WAKE_BIT];

   // Capture address and data in either order
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aw_have_q <= 1'h0;
         w_have_q  <= 1'h0;
         waddr_q   <= '0;
         wbyte_q   <= 8'h00;
         wstrb0_q  <= 1'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'h1;
            waddr_q   <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_have_q <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'h1;
            wbyte_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end else if (do_wr) begin
            w_have_q <= 1'h0;
         end
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bvalid_q <= 1'h0;
         bresp_q  <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_q <= 1'h1;
         bresp_q  <= ppfm_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'h0;
      end
   end

   // Read word selection; status bits show live state
   wire [7:0] cs_rd = {4'h0, half_sync, wake_flag_q, clock_out_gate_q,
                       pwr_q == PPFM_SUSP};
   wire [7:0] rd_byte =
      (s_axi_araddr == OFF_PA_FUNC) ? port_a_function_reg_q :
      (s_axi_araddr == OFF_PC_FUNC) ? port_c_function_reg_q :
      (s_axi_araddr == OFF_PA_OUT)  ? pa_out_q :
      (s_axi_araddr == OFF_PA_DIR)  ? pa_dir_q :
      (s_axi_araddr == OFF_PC_OUT)  ? pc_out_q :
      (s_axi_araddr == OFF_PC_DIR)  ? pc_dir_q :
      (s_axi_araddr == OFF_PA_PIN)  ? pa_sync :
      (s_axi_araddr == OFF_PC_PIN)  ? pc_sync :
      (s_axi_araddr == OFF_CPU_CS)  ? cs_rd : 8'h00;

   // Read answer one cycle after the address is taken
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rvalid_q <= 1'h0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h00000000;
      end else if (rd_go) begin
         rvalid_q <= 1'h1;
         rresp_q  <= ppfm_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_q  <= {24'h000000, rd_byte};
      end else if (s_axi_rready) begin
         rvalid_q <= 1'h0;
      end
   end

   // Function selects and port latches are separate flops, so a
   // select change never disturbs the latched output value
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         port_a_function_reg_q <= RST_FUNC; // [R4] [R6]
         port_c_function_reg_q <= RST_FUNC;
         pa_out_q              <= RST_PORT;
         pa_dir_q              <= RST_PORT;
         pc_out_q              <= RST_PORT;
         pc_dir_q              <= RST_PORT;
         clock_out_gate_q      <= RST_GATE;
      end else begin
         if (wr_pa_fn) port_a_function_reg_q <= wbyte_q & PA_FUNC_MASK; // [R14]
         if (wr_pc_fn) port_c_function_reg_q <= wbyte_q & PC_FUNC_MASK; // [R14]
         if (wr_pa_o)  pa_out_q <= wbyte_q;
         if (wr_pa_d)  pa_dir_q <= wbyte_q;
         if (wr_pc_o)  pc_out_q <= wbyte_q;
         if (wr_pc_d)  pc_dir_q <= wbyte_q;
         if (wr_cs)    clock_out_gate_q <= wbyte_q[CS_GATE_BIT];
      end
   end

   // Alternate values per pin; unused positions are never selected
   wire [7:0] pa_alt = {ppfm_echo(alt.s1_data, alt.s1_mode),   // [R7]
                        ppfm_echo(alt.s0_data, alt.s0_mode),   // [R5]
                        alt.fifo_rd_n, alt.fifo_wr_n,          // [R2] [R3]
                        alt.mem_cs_n, 3'h7};                   // [R1]
   wire [7:0] pc_alt = {alt.mem_rd_n, alt.mem_wr_n, 6'h3F};    // [R8] [R9]

   // Per-pin mux: function select wins, else latch with direction
   for (genvar i = 0; i < 8; i++) begin : g_pin
      assign pa_pins.out[i]  = port_a_function_reg_q[i] ? pa_alt[i] : pa_out_q[i];
      assign pa_pins.oe_n[i] = port_a_function_reg_q[i] ? 1'h0 : ~pa_dir_q[i];
      assign pc_pins.out[i]  = port_c_function_reg_q[i] ? pc_alt[i] : pc_out_q[i];
      assign pc_pins.oe_n[i] = port_c_function_reg_q[i] ? 1'h0 : ~pc_dir_q[i];
   end

   // Reference edge timing; the doubled clock is only as fine as the
   // core clock allows, so expect jitter of one core cycle
   wire ref_edge = ref_sync ^ ref_d_q;
   wire [CNT_W-1:0] cnt_inc = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ref_d_q    <= 1'h0;
         cnt_q      <= '0;
         half_per_q <= '0;
         dbl_q      <= 1'h0;
      end else begin
         ref_d_q <= ref_sync;
         if (ref_edge) begin
            cnt_q      <= '0;
            half_per_q <= cnt_inc;
            dbl_q      <= 1'h1; // [R10]
         end else begin
            cnt_q <= cnt_inc;
            if (cnt_inc >= (half_per_q >> 1)) dbl_q <= 1'h0; // [R10]
         end
      end
   end

   // Clock out pin: gated off and released when the gate bit is low
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clk_out_q  <= 1'h0;
         clk_oe_n_q <= 1'h1;
      end else begin
         clk_out_q  <= clock_out_gate_q & (half_sync ? ref_sync : dbl_q); // [R10]
         clk_oe_n_q <= ~clock_out_gate_q; // [R11]
      end
   end
   assign clock_out_pin  = clk_out_q;
   assign clock_out_oe_n = clk_oe_n_q;

   // Suspend control; a held-low wake input refuses the request
   wire wake_fall = wake_d_q & ~wake_sync;
   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         PPFM_RUN:  if (susp_req && wake_sync) pwr_d = PPFM_SUSP; // [R13]
         PPFM_SUSP: if (wake_fall) pwr_d = PPFM_RUN; // [R12]
      endcase
   end

   // Wake flag: a new wake edge wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pwr_q       <= PPFM_RUN;
         wake_d_q    <= 1'h1;
         wake_flag_q <= 1'h0;
      end else begin
         pwr_q    <= pwr_d;
         wake_d_q <= wake_sync;
         if (pwr_q == PPFM_SUSP && wake_fall) wake_flag_q <= 1'h1; // [R12]
         else if (wake_clr) wake_flag_q <= 1'h0;
      end
   end
   assign osc_run  = (pwr_q == PPFM_RUN);
   assign wake_irq = wake_flag_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   property p_cs_pin;
      port_a_function_reg_q[PA_CS_BIT] |->
         !pa_pins.oe_n[PA_CS_BIT] && pa_pins.out[PA_CS_BIT] == alt.mem_cs_n;
   endproperty
   a_cs_pin: assert property (p_cs_pin) else $error("chip select not on pin"); // [R1]

   property p_cs_input;
      !port_a_function_reg_q[PA_CS_BIT] && !pa_dir_q[PA_CS_BIT] |->
         pa_pins.oe_n[PA_CS_BIT];
   endproperty
   a_cs_input: assert property (p_cs_input) else $error("port bit 3 not input"); // [R1]

   property p_fifo_strobes;
      port_a_function_reg_q[PA_FST_BIT] && port_a_function_reg_q[PA_FLD_BIT] |->
         pa_pins.out[PA_FST_BIT] == alt.fifo_wr_n &&
         pa_pins.out[PA_FLD_BIT] == alt.fifo_rd_n && pa_pins.oe_n[5:4] == 2'h0;
   endproperty
   a_fifo_strobes: assert property (p_fifo_strobes) else $error("fifo strobe wrong"); // [R2] [R3]

   property p_echo0_idle;
      port_a_function_reg_q[PA_RX0_BIT] && alt.s0_mode != SER_SYNC |->
         pa_pins.out[PA_RX0_BIT];
   endproperty
   a_echo0_idle: assert property (p_echo0_idle) else $error("echo 0 not high"); // [R5]

   property p_echo1_data;
      port_a_function_reg_q[PA_RX1_BIT] && alt.s1_mode == SER_SYNC |->
         pa_pins.out[PA_RX1_BIT] == alt.s1_data;
   endproperty
   a_echo1_data: assert property (p_echo1_data) else $error("echo 1 data wrong"); // [R7]

   property p_mem_strobes;
      port_c_function_reg_q[PC_WR_BIT] && port_c_function_reg_q[PC_RD_BIT] |->
         pc_pins.out[7:6] == {alt.mem_rd_n, alt.mem_wr_n} && pc_pins.oe_n[7:6] == 2'h0;
   endproperty
   a_mem_strobes: assert property (p_mem_strobes) else $error("memory strobe wrong"); // [R8] [R9]

   property p_half_clock;
      clock_out_gate_q && half_sync |=> clock_out_pin == $past(ref_sync);
   endproperty
   a_half_clock: assert property (p_half_clock) else $error("reduced clock wrong"); // [R10]

   property p_gate_off;
      $fell(clock_out_gate_q) |=> clock_out_oe_n && !clock_out_pin;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("clock out still driven"); // [R11]

   property p_wake_up;
      pwr_q == PPFM_SUSP && wake_fall |=> osc_run && wake_irq;
   endproperty
   a_wake_up: assert property (p_wake_up) else $error("wake edge ignored"); // [R12]

   property p_no_suspend;
      pwr_q == PPFM_RUN && !wake_sync |=> osc_run;
   endproperty
   a_no_suspend: assert property (p_no_suspend) else $error("suspended while held"); // [R13]

   property p_latch_kept;
      wr_pa_fn |=> $stable(pa_out_q) ##0 port_a_function_reg_q == $past(wbyte_q & PA_FUNC_MASK);
   endproperty
   a_latch_kept: assert property (p_latch_kept) else $error("select write slipped"); // [R14]

   c_suspend: cover property (pwr_q == PPFM_RUN ##1 pwr_q == PPFM_SUSP);
   c_wake:    cover property (pwr_q == PPFM_SUSP ##1 pwr_q == PPFM_RUN);
   c_cs_sel:  cover property ($rose(port_a_function_reg_q[PA_CS_BIT]));
   c_gate:    cover property ($fell(clock_out_gate_q));
endmodule : ppfm_top
